// file: hdl/icsr_regs.svh
// Register selectors, field positions and fixed values of the interface register bank.
`ifndef ICSR_REGS_SVH
`define ICSR_REGS_SVH
`define ICSR_SEL_SELECT_EL1 4'h0
`define ICSR_SEL_SELECT_EL2 4'h1
`define ICSR_SEL_SELECT_EL3 4'h2
`define ICSR_SEL_ACTIVE_G0 4'h3
`define ICSR_SEL_ACTIVE_G1 4'h4
`define ICSR_SEL_SPLIT_G0 4'h5
`define ICSR_SEL_SPLIT_G1 4'h6
`define ICSR_SEL_VIRT_CTRL 4'h7
`define ICSR_SEL_END_G0 4'h8
`define ICSR_SEL_END_G1 4'h9
`define ICSR_SEL_DEACT 4'ha
`define ICSR_BIT_SRE 0
`define ICSR_BIT_FIQ_OFF 1
`define ICSR_BIT_IRQ_OFF 2
`define ICSR_BIT_LOWER_OK 3
`define ICSR_BIT_END_MODE 1
`define ICSR_BIT_SHARED_SPLIT 0
`define ICSR_CTRL_FIXED 32'h0000_8400
`define ICSR_SPLIT_MIN_G0 3'h2
`define ICSR_SPLIT_MIN_G1_S 3'h2
`define ICSR_SPLIT_MIN_G1_NS 3'h3
`define ICSR_SPLIT_RESET_G0 3'h2
`define ICSR_SPLIT_RESET_G1 3'h3
`define ICSR_SPLIT_MAX 3'h7
`define ICSR_ACTIVE_RESET 32'h0000_0000
`endif

// file: hdl/icsr_pkg.sv
// Types shared by the interface register bank.
package icsr_pkg;
  typedef logic [3:0] icsr_sel_t;
  typedef logic [31:0] icsr_word_t;
  typedef logic [2:0] icsr_split_t;
endpackage

// file: hdl/icsr_bank.sv
// System-register bank of the virtual interrupt-controller CPU interface.
`timescale 1ns/1ns
`include "icsr_regs.svh"
module icsr_bank #(
  parameter bit HAS_HYP = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire icsr_pkg::icsr_sel_t sel_i,
  input wire logic secure_i,
  input wire logic from_el3_i,
  input wire icsr_pkg::icsr_word_t wdata_i,
  output icsr_pkg::icsr_word_t rdata_o,
  output logic irq_bypass_off_o,
  output logic fiq_bypass_off_o,
  output logic virt_end_split_mode_o,
  output logic virt_shared_split_point_o,
  output icsr_pkg::icsr_split_t split_g0_o,
  output icsr_pkg::icsr_split_t split_g1_o,
  output logic prio_drop_o,
  output logic deactivate_o,
  output logic deact_unpredictable_o
);
  import icsr_pkg::*;

  // Elaboration-time guard: the hidden level-2 view needs a two-valued switch.
  if (HAS_HYP !== 1'b0 && HAS_HYP !== 1'b1) begin : g_bad_hyp
    $error("HAS_HYP must be 0 or 1");
  end

  logic irq_bypass_off;
  logic fiq_bypass_off;
  logic end_mode;
  logic shared_split;
  icsr_word_t virt_active_prio_grp0;
  icsr_word_t virt_active_prio_grp1;
  icsr_split_t split_g0;
  icsr_split_t split_g1;
  icsr_split_t min_g1;
  icsr_split_t wsplit;
  icsr_split_t g1_read;
  icsr_split_t next_split_g0;
  icsr_split_t next_split_g1;
  icsr_word_t sel_word;
  icsr_word_t next_rdata;
  logic el2_hidden;
  logic wr_sel_view;
  logic wr_end;
  logic wr_deact;

  // Access decode for the select views and the end-of-interrupt writes.
  assign el2_hidden = !HAS_HYP && from_el3_i && sel_i == `ICSR_SEL_SELECT_EL2;
  assign wr_sel_view = wr_i && !el2_hidden && (sel_i == `ICSR_SEL_SELECT_EL1 ||
                       sel_i == `ICSR_SEL_SELECT_EL2 || sel_i == `ICSR_SEL_SELECT_EL3);
  assign wr_end = wr_i && (sel_i == `ICSR_SEL_END_G0 || sel_i == `ICSR_SEL_END_G1);
  assign wr_deact = wr_i && sel_i == `ICSR_SEL_DEACT;

  assign wsplit = wdata_i[2:0];
  assign min_g1 = secure_i ? `ICSR_SPLIT_MIN_G1_S : `ICSR_SPLIT_MIN_G1_NS;
  assign next_split_g0 = (wsplit < `ICSR_SPLIT_MIN_G0) ? `ICSR_SPLIT_MIN_G0 : wsplit;
  assign next_split_g1 = (wsplit < min_g1) ? min_g1 : wsplit;

  assign g1_read = !shared_split ? split_g1 :
                   (split_g0 == `ICSR_SPLIT_MAX) ? `ICSR_SPLIT_MAX : split_g0 + 3'h1;

  // Select-register read image; fixed bits are constants.
  always_comb begin
    sel_word = 32'h0000_0000;
    sel_word[`ICSR_BIT_SRE] = 1'b1;
    sel_word[`ICSR_BIT_IRQ_OFF] = irq_bypass_off;
    sel_word[`ICSR_BIT_FIQ_OFF] = fiq_bypass_off;
    sel_word[`ICSR_BIT_LOWER_OK] = (sel_i != `ICSR_SEL_SELECT_EL1);
  end

  // Read multiplexer; unmapped selectors read as zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (sel_i)
      `ICSR_SEL_SELECT_EL1, `ICSR_SEL_SELECT_EL3: begin
        next_rdata = sel_word;
      end
      `ICSR_SEL_SELECT_EL2: begin
        next_rdata = el2_hidden ? 32'h0000_0000 : sel_word;
      end
      `ICSR_SEL_ACTIVE_G0: begin
        next_rdata = virt_active_prio_grp0;
      end
      `ICSR_SEL_ACTIVE_G1: begin
        next_rdata = virt_active_prio_grp1;
      end
      `ICSR_SEL_SPLIT_G0: begin
        next_rdata = {29'h0, split_g0};
      end
      `ICSR_SEL_SPLIT_G1: begin
        next_rdata = {29'h0, g1_read};
      end
      `ICSR_SEL_VIRT_CTRL: begin
        next_rdata = `ICSR_CTRL_FIXED | {30'h0, end_mode, shared_split};
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Bypass-disable storage common to the three select views; the level-2 view neither reads nor writes it while hidden.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_bypass_off <= 1'b0;
      fiq_bypass_off <= 1'b0;
    end else if (wr_sel_view) begin
      irq_bypass_off <= wdata_i[`ICSR_BIT_IRQ_OFF];
      fiq_bypass_off <= wdata_i[`ICSR_BIT_FIQ_OFF];
    end
  end

  // Active-priority registers, one bit per priority level.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      virt_active_prio_grp0 <= `ICSR_ACTIVE_RESET;
      virt_active_prio_grp1 <= `ICSR_ACTIVE_RESET;
    end else if (wr_i) begin
      if (sel_i == `ICSR_SEL_ACTIVE_G0) begin
        virt_active_prio_grp0 <= wdata_i;
      end
      if (sel_i == `ICSR_SEL_ACTIVE_G1) begin
        virt_active_prio_grp1 <= wdata_i;
      end
    end
  end

  // Split points and control bits.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      split_g0 <= `ICSR_SPLIT_RESET_G0;
      split_g1 <= `ICSR_SPLIT_RESET_G1;
      end_mode <= 1'b0;
      shared_split <= 1'b0;
    end else if (wr_i) begin
      if (sel_i == `ICSR_SEL_SPLIT_G0) begin
        split_g0 <= next_split_g0;
      end
      if (sel_i == `ICSR_SEL_SPLIT_G1 && !shared_split) begin
        split_g1 <= next_split_g1;
      end
      if (sel_i == `ICSR_SEL_VIRT_CTRL) begin
        end_mode <= wdata_i[`ICSR_BIT_END_MODE];
        shared_split <= wdata_i[`ICSR_BIT_SHARED_SPLIT];
      end
    end
  end

  // Registered read data, updated on every read.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end
  end

  // Settings offered to the prioritisation logic.
  assign irq_bypass_off_o = irq_bypass_off;
  assign fiq_bypass_off_o = fiq_bypass_off;
  assign virt_end_split_mode_o = end_mode;
  assign virt_shared_split_point_o = shared_split;
  assign split_g0_o = split_g0;
  assign split_g1_o = shared_split ? split_g0 : split_g1;

  // End-of-interrupt effects as one-cycle strobes.
  // drop and deactivate
  assign prio_drop_o = wr_end;
  assign deactivate_o = end_mode ? wr_deact : wr_end;
  assign deact_unpredictable_o = wr_deact && !end_mode;
endmodule

// file: tb/icsr_bank_properties.sv
// Port checks for the interface register bank.
`timescale 1ns/1ns
module icsr_bank_props (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire icsr_pkg::icsr_sel_t sel_i,
  input wire icsr_pkg::icsr_word_t wdata_i,
  input wire icsr_pkg::icsr_word_t rdata_o,
  input wire logic irq_bypass_off_o,
  input wire logic virt_end_split_mode_o,
  input wire logic virt_shared_split_point_o,
  input wire icsr_pkg::icsr_split_t split_g0_o,
  input wire icsr_pkg::icsr_split_t split_g1_o,
  input wire logic prio_drop_o,
  input wire logic deactivate_o,
  input wire logic deact_unpredictable_o
);
  import icsr_pkg::*;
  // All checks run on the core clock and rest during reset.
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  bypass_write_a: assert property (wr_i && sel_i == 4'h0 |=> irq_bypass_off_o == $past(wdata_i[2]))
    else $error("bypass bit not stored");
  ctrl_fixed_a: assert property (rd_i && sel_i == 4'h7 |=> rdata_o[15:8] == 8'h84)
    else $error("control fixed bits wrong");
  iface_bit0_a: assert property (rd_i && sel_i < 4'h3 |=> rdata_o[0])
    else $error("select bit 0 not one");
  split_floor_a: assert property (split_g0_o >= 3'h2)
    else $error("group 0 split below floor");
  shared_g1_a: assert property (virt_shared_split_point_o |-> split_g1_o == split_g0_o)
    else $error("shared split not followed");
  end_drop_a: assert property (wr_i && sel_i inside {4'h8, 4'h9} |-> prio_drop_o)
    else $error("no priority drop");
  end_deact_a: assert property (wr_i && sel_i == 4'h8 |-> deactivate_o == !virt_end_split_mode_o)
    else $error("end write deactivation wrong");
  dir_unpred_a: assert property (wr_i && sel_i == 4'ha |-> deact_unpredictable_o == !virt_end_split_mode_o)
    else $error("deactivate flag wrong");
  dir_deact_a: assert property (wr_i && sel_i == 4'ha && virt_end_split_mode_o |-> deactivate_o)
    else $error("deactivate write ignored");
endmodule
bind icsr_bank icsr_bank_props i_props (.*);

// file: tb/icsr_core_model.sv
// Behavioural core issuing register reads and writes.
`timescale 1ns/1ns
module icsr_core_model (
  input wire logic clk_i,
  input wire icsr_pkg::icsr_word_t rdata_i,
  output logic wr_o,
  output logic rd_o,
  output icsr_pkg::icsr_sel_t sel_o,
  output logic secure_o,
  output logic el3_o,
  output icsr_pkg::icsr_word_t wdata_o
);
  import icsr_pkg::*;
  // Idle bus at time zero.
  initial begin
    {wr_o, rd_o, secure_o, el3_o} = 4'h0;
    sel_o = 4'h0;
    wdata_o = 32'h0;
  end
  // One access held over one rising edge; stale data is inverted after release.
  task automatic acc(input logic w, input icsr_sel_t s, input icsr_word_t d, input logic sec,
                     output icsr_word_t q);
    @(negedge clk_i);
    {wr_o, rd_o, secure_o} = {w, !w, sec};
    sel_o = s;
    wdata_o = d;
    @(negedge clk_i);
    q = rdata_i;
    {wr_o, rd_o} = 2'h0;
    wdata_o = ~d;
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the interface register bank.
`timescale 1ns/1ns
module testbench;
  import icsr_pkg::*;
  logic clk_i, reset_i, wr_i, rd_i, secure_i, from_el3_i, irq_bypass_off_o, fiq_bypass_off_o;
  logic virt_end_split_mode_o, virt_shared_split_point_o, prio_drop_o, deactivate_o;
  logic deact_unpredictable_o;
  icsr_sel_t sel_i;
  icsr_word_t wdata_i, rdata_o, q;
  icsr_split_t split_g0_o, split_g1_o;
  int failures = 0;
  int num_checks = 0;
  icsr_bank i_icsr_bank (.*);
  icsr_core_model i_icsr_core_model (.clk_i, .rdata_i(rdata_o), .wr_o(wr_i), .rd_o(rd_i),
    .sel_o(sel_i), .secure_o(secure_i), .el3_o(from_el3_i), .wdata_o(wdata_i));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input icsr_word_t e, input icsr_word_t g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input icsr_sel_t s, input icsr_word_t d, input logic sec = 1'b0);
    i_icsr_core_model.acc(1'b1, s, d, sec, q);
  endtask
  task automatic rd(input icsr_sel_t s, input icsr_word_t e, input string n);
    i_icsr_core_model.acc(1'b0, s, 32'h0, 1'b0, q);
    chk(n, e, q);
  endtask
  task automatic t_select();
    wr(4'h2, 32'hffff_fff6);
    rd(4'h0, 32'h7, "select el1");
    rd(4'h1, 32'hf, "select el2");
    wr(4'h0, 32'h4);
    rd(4'h2, 32'hd, "select el3");
    chk("fiq off", 32'h0, {31'h0, fiq_bypass_off_o});
  endtask
  task automatic t_active();
    rd(4'h3, 32'h0, "active g0");
    wr(4'h3, 32'h8000_0001);
    wr(4'h4, 32'h2);
    rd(4'h3, 32'h8000_0001, "active g0");
    rd(4'h4, 32'h2, "active g1");
  endtask
  task automatic t_shared();
    wr(4'h6, 32'h4);
    wr(4'h7, 32'h1);
    wr(4'h5, 32'h5);
    rd(4'h6, 32'h6, "split g1 shared");
    wr(4'h6, 32'h2);
    wr(4'h5, 32'h7);
    rd(4'h6, 32'h7, "split g1 top");
    wr(4'h7, 32'h0);
    rd(4'h6, 32'h4, "split g1 kept");
    chk("split g1 out", 32'h4, {29'h0, split_g1_o});
  endtask
  task automatic t_split();
    wr(4'h5, 32'h1);
    rd(4'h5, 32'h2, "split g0 floor");
    wr(4'h6, 32'h1);
    rd(4'h6, 32'h3, "split g1 ns");
    wr(4'h6, 32'h0, 1'b1);
    rd(4'h6, 32'h2, "split g1 s");
  endtask
  task automatic t_end();
    rd(4'h7, 32'h8400, "ctrl");
    wr(4'h8, 32'h1);
    wr(4'ha, 32'h1);
    wr(4'h7, 32'h2);
    rd(4'h7, 32'h8402, "ctrl mode");
    wr(4'h9, 32'h1);
    wr(4'ha, 32'h1);
    wr(4'h8, 32'h1);
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog cuts a hang short.
  initial begin
    repeat (2000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end
  // Reset, then the scenarios in turn.
  initial begin
    reset_i = 1'b1;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    t_end();
    t_select();
    t_active();
    t_shared();
    t_split();
    tally_and_finish();
  end
endmodule
